// file: include/pld_pkg.sv
// Package with register map, field layout, reset values and timing of the link-drop and test config block.
package pld_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_TEST_CHANNEL_CONTROL = 8'h25;
    localparam logic [7:0] IDX_CROSSOVER_TIMER_CONFIG = 8'h2C;
    localparam logic [7:0] IDX_LINK_DROP_CONFIG = 8'h2D;
    localparam logic [7:0] IDX_LINK_DROP_THRESHOLD = 8'h2E;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] IDX_MODE_CONTROL = 8'h42;

    localparam int TCC_ALL_BIT = 7;
    localparam int TCC_SEL_LSB = 5;
    localparam int LDC_FORCE_BIT = 15;
    localparam int LDC_EN_BIT = 14;
    localparam int LDC_FLAG_LSB = 8;
    localparam int NUM_SRC = 5;
    localparam int MODE_AUTOX_BIT = 0;

    localparam logic [7:0] TCC_HIGH_RESET = 8'h04;
    localparam logic [11:0] XT_HIGH_RESET = 12'h141;
    localparam logic [3:0] XT_TIMER_RESET = 4'hF;
    localparam logic [2:0] THR_HIGH_RESET = 3'h2;
    localparam logic [2:0] THR_MID_RESET = 3'h2;
    localparam logic [2:0] THR_ENERGY_RESET = 3'h1;
    localparam logic [2:0] THR_ENERGY_STRAP = 3'h2;

    localparam int CLK_HZ = 40000000;
    localparam int XT_STEP_MS = 32;
    localparam int XT_STEP_CYCLES = (CLK_HZ / 1000) * XT_STEP_MS;

    typedef enum logic [1:0] {
        PLD_CH_A = 2'b00,
        PLD_CH_B = 2'b01,
        PLD_CH_C = 2'b10,
        PLD_CH_D = 2'b11
    } pld_channel_e;
endpackage

// file: rtl/pld_regs.sv
// Register bank for test channel routing, crossover timer and quick link loss detection.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - All-channels bit set drives the selected test mode on all four channels.
// - Otherwise the two-bit select picks one channel, 00 A through 11 D.
// - Crossover timer has effect only while robust auto-crossover is enabled.
// - Timer period is 32 ms times code plus one; resets to 0xF.
// - Force-drop bit makes the partner drop link when no signal is received.
// - Quick link loss detection acts only while its enable bit is one.
// - An enabled source causing a drop latches its own status flag high.
// - Five per-source enables, reset to zero, bit 4 sync loss to 0 energy.
// - Energy-lost asserts when the energy accumulator drops below the threshold, reset 0x1.
// - With the strap enabling quick link loss, the threshold defaults to 0x2.
module pld_regs
    import pld_pkg::*;
#(
    parameter int ACC_W = 8,
    parameter int STEP_CYCLES = pld_pkg::XT_STEP_CYCLES
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Strap and line status
    input wire logic strap_quick_link_loss_i,
    input wire logic link_up_i,
    input wire logic signal_detect_i,
    input wire logic sync_loss_i,
    input wire logic rx_error_i,
    input wire logic mlt3_error_i,
    input wire logic snr_low_i,
    input wire logic [ACC_W-1:0] energy_acc_i,
    // Controls toward the PHY core
    input wire logic test_mode_active_i,
    output logic [3:0] test_channel_en_o,
    output logic crossover_timer_expired_o,
    output logic force_partner_drop_o,
    output logic quick_link_drop_o,
    output logic [2:0] energy_loss_threshold_o,
    output logic irq_o
);
    import pld_pkg::*;

    logic [15:0] tcc, next_tcc;
    logic [15:0] xtc, next_xtc;
    logic force_drop, next_force_drop;
    logic ql_en, next_ql_en;
    logic [NUM_SRC-1:0] src_en, next_src_en;
    logic [NUM_SRC-1:0] flags, next_flags;
    logic [2:0] thr_high, next_thr_high;
    logic [2:0] thr_mid, next_thr_mid;
    logic [2:0] thr, next_thr;
    logic [1:0] irq_sts, next_irq_sts;
    logic [1:0] irq_mask, next_irq_mask;
    logic autox_en, next_autox_en;
    logic strap_done, next_strap_done;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic [31:0] timer_cnt, next_timer_cnt;
    logic [3:0] step_cnt, next_step_cnt;
    logic expired, next_expired;
    logic drop, next_drop;

    logic req;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [15:0] wdat;
    logic [NUM_SRC-1:0] cond;
    logic [NUM_SRC-1:0] cause;
    logic energy_lost;
    logic [1:0] irq_evt;

    assign req = wb_cyc_i && wb_stb_i && !ack;
    assign idx = wb_adr_i[9:2];
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    // Lower two byte lanes carry the 16-bit registers; unselected lanes keep their old value.
    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = old;
        if (wb_sel_i[0])
        begin
            merge[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
            merge[15:8] = wb_dat_i[15:8];
        end
    endfunction
    assign wdat = wb_dat_i[15:0];

    assign energy_lost = !signal_detect_i || (energy_acc_i < ACC_W'(thr));
    assign cond = {sync_loss_i, rx_error_i, mlt3_error_i, snr_low_i, energy_lost};
    assign cause = (ql_en && link_up_i) ? (cond & src_en) : '0;
    assign irq_evt = {|cause, expired && !crossover_timer_expired_o};

    // Register file and latched flags.
    always_comb
    begin
        logic [15:0] m;
        m = '0;
        next_tcc = tcc;
        next_xtc = xtc;
        next_force_drop = force_drop;
        next_ql_en = ql_en;
        next_src_en = src_en;
        next_thr_high = thr_high;
        next_thr_mid = thr_mid;
        next_thr = thr;
        next_irq_mask = irq_mask;
        next_autox_en = autox_en;
        next_strap_done = 1'b1;
        next_ack = req;
        next_rdata = rdata;
        next_flags = flags;
        next_irq_sts = irq_sts;
        // Strap is sampled once, in the first cycle after reset release.
        if (!strap_done && strap_quick_link_loss_i)
        begin
            next_thr = THR_ENERGY_STRAP;
            next_ql_en = 1'b1;
        end
        if (rd)
        begin
            unique case (idx)
                IDX_TEST_CHANNEL_CONTROL: next_rdata = {16'h0000, tcc};
                IDX_CROSSOVER_TIMER_CONFIG: next_rdata = {16'h0000, xtc};
                IDX_LINK_DROP_CONFIG:
                begin
                    next_rdata = {16'h0000, force_drop, ql_en, 1'b0, flags, 3'b000, src_en};
                    next_flags = '0;
                end
                IDX_LINK_DROP_THRESHOLD: next_rdata = {21'h0, thr_high, 1'b0, thr_mid, 1'b0, thr};
                IDX_IRQ_STATUS: next_rdata = {30'h0, irq_sts};
                IDX_IRQ_MASK: next_rdata = {30'h0, irq_mask};
                IDX_MODE_CONTROL: next_rdata = {31'h0, autox_en};
                default: next_rdata = '0;
            endcase
        end
        if (wr)
        begin
            unique case (idx)
                IDX_TEST_CHANNEL_CONTROL:
                begin
                    m = merge(tcc);
                    next_tcc = {m[15:5], 5'h00};
                end
                IDX_CROSSOVER_TIMER_CONFIG: next_xtc = merge(xtc);
                IDX_LINK_DROP_CONFIG:
                begin
                    m = merge({force_drop, ql_en, 1'b0, flags, 3'b000, src_en});
                    next_force_drop = m[LDC_FORCE_BIT];
                    next_ql_en = m[LDC_EN_BIT];
                    next_src_en = m[NUM_SRC-1:0];
                end
                IDX_LINK_DROP_THRESHOLD:
                begin
                    m = merge({5'h00, thr_high, 1'b0, thr_mid, 1'b0, thr});
                    next_thr_high = m[10:8];
                    next_thr_mid = m[6:4];
                    next_thr = m[2:0];
                end
                IDX_IRQ_STATUS: next_irq_sts = irq_sts & ~(wdat[1:0] & {2{wb_sel_i[0]}});
                IDX_IRQ_MASK:
                begin
                    if (wb_sel_i[0])
                    begin
                        next_irq_mask = wdat[1:0];
                    end
                end
                IDX_MODE_CONTROL:
                begin
                    if (wb_sel_i[0])
                    begin
                        next_autox_en = wdat[MODE_AUTOX_BIT];
                    end
                end
                default: next_ack = req;
            endcase
        end
        // Set wins over a read clear or a write-one clear in the same cycle.
        next_flags = next_flags | cause | (flags & cond & {NUM_SRC{rd && idx == IDX_LINK_DROP_CONFIG}});
        next_irq_sts = next_irq_sts | irq_evt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tcc <= {TCC_HIGH_RESET, 8'h00};
            xtc <= {XT_HIGH_RESET, XT_TIMER_RESET};
            force_drop <= 1'b0;
            ql_en <= 1'b0;
            src_en <= '0;
            flags <= '0;
            thr_high <= THR_HIGH_RESET;
            thr_mid <= THR_MID_RESET;
            thr <= THR_ENERGY_RESET;
            irq_sts <= '0;
            irq_mask <= '0;
            autox_en <= 1'b0;
            strap_done <= 1'b0;
            ack <= 1'b0;
            rdata <= '0;
        end
        else
        begin
            tcc <= next_tcc;
            xtc <= next_xtc;
            force_drop <= next_force_drop;
            ql_en <= next_ql_en;
            src_en <= next_src_en;
            flags <= next_flags;
            thr_high <= next_thr_high;
            thr_mid <= next_thr_mid;
            thr <= next_thr;
            irq_sts <= next_irq_sts;
            irq_mask <= next_irq_mask;
            autox_en <= next_autox_en;
            strap_done <= next_strap_done;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // Crossover retry timer: counts 32 ms steps, held idle while robust mode is off.
    always_comb
    begin
        next_timer_cnt = timer_cnt;
        next_step_cnt = step_cnt;
        next_expired = 1'b0;
        if (!autox_en)
        begin
            next_timer_cnt = '0;
            next_step_cnt = '0;
        end
        else if (timer_cnt == 32'(STEP_CYCLES - 1))
        begin
            next_timer_cnt = '0;
            if (step_cnt == xtc[3:0])
            begin
                next_step_cnt = '0;
                next_expired = 1'b1;
            end
            else
            begin
                next_step_cnt = step_cnt + 4'h1;
            end
        end
        else
        begin
            next_timer_cnt = timer_cnt + 32'h1;
        end
        next_drop = |cause;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_cnt <= '0;
            step_cnt <= '0;
            expired <= 1'b0;
            drop <= 1'b0;
            crossover_timer_expired_o <= 1'b0;
        end
        else
        begin
            timer_cnt <= next_timer_cnt;
            step_cnt <= next_step_cnt;
            expired <= next_expired;
            drop <= next_drop;
            crossover_timer_expired_o <= expired;
        end
    end

    // Test pattern routing: a one-hot lane enable, or all lanes.
    always_comb
    begin
        test_channel_en_o = '0;
        if (test_mode_active_i)
        begin
            if (tcc[TCC_ALL_BIT])
            begin
                test_channel_en_o = 4'hF;
            end
            else
            begin
                test_channel_en_o = 4'h1 << tcc[TCC_SEL_LSB +: 2];
            end
        end
    end

    assign force_partner_drop_o = force_drop && !signal_detect_i;
    assign quick_link_drop_o = drop;
    assign energy_loss_threshold_o = thr;
    // A mask bit of one hides its status bit from the interrupt line; the status bit still latches.
    assign irq_o = |(irq_sts & ~irq_mask);
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    AST_FLAG_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        cause[0] |=> flags[0]) else $error("energy flag not latched");
    AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (flags[4] && !(rd && idx == IDX_LINK_DROP_CONFIG)) |=> flags[4]) else $error("flag lost without read");
    AST_EN_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        !ql_en |=> !drop) else $error("drop while disabled");
    AST_SRC_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        (ql_en && link_up_i && cond[2] && !src_en[2]) |-> !cause[2]) else $error("disabled source acted");
    AST_ALL_CH: assert property (@(posedge clk_i) disable iff (rst_i)
        (test_mode_active_i && tcc[TCC_ALL_BIT]) |-> test_channel_en_o == 4'hF) else $error("not all lanes");
    AST_ONE_CH: assert property (@(posedge clk_i) disable iff (rst_i)
        (test_mode_active_i && !tcc[TCC_ALL_BIT]) |-> $onehot(test_channel_en_o)) else $error("lane not one-hot");
    AST_TIMER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !autox_en [*2] |-> !expired) else $error("timer ran while off");
    AST_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
        (force_drop && !signal_detect_i) |-> force_partner_drop_o) else $error("force drop missing");
    AST_STRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        (!strap_done && strap_quick_link_loss_i && !wr) |=> thr == THR_ENERGY_STRAP) else $error("strap threshold");
endmodule
`default_nettype wire

// file: verification/pld_link_partner.sv
// Behavioural remote link partner that sends energy, trains a link and drops it on request.
`timescale 1ns/10ps
`default_nettype none
module pld_link_partner #(
    parameter int UP_CYCLES = 3
)(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench command and device request
    input wire logic transmit_i,
    input wire logic force_drop_i,
    // Line status seen by the device
    output logic signal_detect_o,
    output logic link_up_o
);
    int count;
    assign signal_detect_o = transmit_i;
    // The link needs a few cycles of energy before it counts as up, so a dropped link is not back at once.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !transmit_i || force_drop_i)
            count <= 0;
        else if (count < UP_CYCLES)
            count <= count + 1;
    end
    assign link_up_o = (count == UP_CYCLES);
endmodule
`default_nettype wire

// file: verification/phy_link_drop_and_test_config_tb.sv
// Self-checking bench for the link-drop and test config register block.
`timescale 1ns/10ps
`default_nettype none
module phy_link_drop_and_test_config_tb;
    import pld_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, strap = 1'b0;
    logic tx_on = 1'b0, tm_act = 1'b0, ack, xt, fpd, qld, irq, sd, lu;
    logic [9:0] adr = 10'h000;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [3:0] sel = 4'h0, en;
    logic [4:0] cause = 5'h00;
    logic [2:0] thr;
    int errors = 0;
    int n_checks = 0;
    int n;
    always #12.5 clk_i = ~clk_i;
    pld_regs #(.ACC_W(8), .STEP_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .strap_quick_link_loss_i(strap), .link_up_i(lu), .signal_detect_i(sd), .sync_loss_i(cause[4]),
        .rx_error_i(cause[3]), .mlt3_error_i(cause[2]), .snr_low_i(cause[1]),
        .energy_acc_i(cause[0] ? 8'h00 : 8'hFF), .test_mode_active_i(tm_act), .test_channel_en_o(en),
        .crossover_timer_expired_o(xt), .force_partner_drop_o(fpd), .quick_link_drop_o(qld),
        .energy_loss_threshold_o(thr), .irq_o(irq));
    pld_link_partner pt_u (.clk_i(clk_i), .rst_i(rst_i), .transmit_i(tx_on), .force_drop_i(fpd),
        .signal_detect_o(sd), .link_up_o(lu));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; the answer is awaited at rising edges only, bounded by a count.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {16'h0000, d};
        sel <= 4'h3;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
            errors++;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 16'h0000);
        chk(q, exp);
    endtask
    task automatic wait_pulse;
        n = 0;
        while (xt !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200)
            errors++;
    endtask
    task automatic t_reset;
        rd(8'h25, 32'h0400);
        rd(8'h2C, 32'h141F);
        rd(8'h2D, 32'h0000);
        rd(8'h2E, 32'h0221);
        wb(1'b1, 8'h3F, 16'hFFFF);
        rd(8'h3F, 32'h0000);
        chk(thr, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_channel;
        tm_act <= 1'b1;
        for (int a = 0; a < 2; a++)
        begin
            for (int s = 0; s < 4; s++)
            begin
                wb(1'b1, 8'h25, {8'h04, a[0], s[1:0], 5'h00});
                #1 chk(en, a ? 32'hF : 32'h1 << s);
            end
        end
        @(posedge clk_i);
        tm_act <= 1'b0;
        @(posedge clk_i);
        #1 chk(en, 32'h0);
        $display("channel test done");
    endtask
    task automatic t_timer(input logic [3:0] code);
        wb(1'b1, 8'h42, 16'h0000);
        wb(1'b1, 8'h2C, 16'h1410 | code);
        repeat (100)
        begin
            @(posedge clk_i);
            #1 chk(xt, 32'h0);
        end
        wb(1'b1, 8'h42, 16'h0001);
        wait_pulse();
        @(posedge clk_i);
        wait_pulse();
        chk(n + 1, 4 * (code + 1));
        wb(1'b1, 8'h42, 16'h0000);
        $display("timer test done");
    endtask
    task automatic t_drop;
        tx_on <= 1'b1;
        repeat (10) @(posedge clk_i);
        wb(1'b1, 8'h2D, 16'h001F);
        cause <= 5'h1F;
        @(posedge clk_i);
        cause <= 5'h00;
        #1 chk(qld, 32'h0);
        rd(8'h2D, 32'h001F);
        for (int s = 0; s < 5; s++)
        begin
            wb(1'b1, 8'h2D, 16'h4000 | (16'h1 << s));
            cause <= 5'h01 << s;
            @(posedge clk_i);
            cause <= 5'h00;
            #1 chk(qld, 32'h1);
            rd(8'h2D, 32'h4000 | (32'h101 << s));
            rd(8'h2D, 32'h4000 | (32'h1 << s));
        end
        wb(1'b1, 8'h2D, 16'h8000);
        #1 chk(fpd, 32'h0);
        @(posedge clk_i);
        tx_on <= 1'b0;
        #1 chk(fpd, 32'h1);
        @(posedge clk_i);
        #1 chk(lu, 32'h0);
        wb(1'b1, 8'h2D, 16'h0000);
        $display("drop test done");
    endtask
    task automatic t_irq;
        wb(1'b1, 8'h41, 16'h0000);
        // Timer expiries and quick drops from the earlier tests must both have latched.
        rd(8'h40, 32'h3);
        chk(irq, 32'h1);
        wb(1'b1, 8'h40, 16'h0003);
        rd(8'h40, 32'h0);
        chk(irq, 32'h0);
        wb(1'b1, 8'h42, 16'h0001);
        wait_pulse();
        wb(1'b1, 8'h42, 16'h0000);
        rd(8'h40, 32'h1);
        chk(irq, 32'h1);
        wb(1'b1, 8'h41, 16'h0001);
        #1 chk(irq, 32'h0);
        wb(1'b1, 8'h41, 16'h0000);
        #1 chk(irq, 32'h1);
        wb(1'b1, 8'h40, 16'h0001);
        #1 chk(irq, 32'h0);
        $display("irq test done");
    endtask
    task automatic t_strap;
        @(posedge clk_i);
        strap <= 1'b1;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h2E, 32'h0222);
        rd(8'h2D, 32'h4000);
        wb(1'b1, 8'h2E, 16'h0221);
        strap <= 1'b0;
        #1 chk(thr, 32'h1);
        $display("strap test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_channel();
        t_timer(4'h0);
        t_timer(4'hF);
        t_drop();
        t_irq();
        t_strap();
        tally_and_finish();
    end
    // The tests need well under a thousand cycles; this span leaves a wide margin.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
